// *** logic/ecm_pkg.sv ***
`default_nettype none
package ecm_pkg;
   // register indices; bus byte address is four times the index
   localparam logic [15:0] PROG_CFG_IDX     = 16'ha00d;
   localparam logic [15:0] PROG_FA_LO_IDX   = 16'ha00e;
   localparam logic [15:0] PROG_FA_HI_IDX   = 16'ha00f;
   localparam logic [15:0] RST_CTRL_IDX     = 16'ha017;
   localparam logic [15:0] DATA_CFG_IDX     = 16'ha02d;
   localparam logic [15:0] DATA_FA_LO_IDX   = 16'ha02e;
   localparam logic [15:0] DATA_FA_HI_IDX   = 16'ha02f;

   // field positions
   localparam int CFG_EN_BIT       = 7;
   localparam int UNCORR_IEN_BIT   = 5;
   localparam int CORR_IEN_BIT     = 4;
   localparam int UNCORR_FLAG_BIT  = 1;
   localparam int CORR_FLAG_BIT    = 0;
   localparam int RST_EN_BIT       = 6;

   // reset values
   localparam logic [7:0]  DATA_CFG_RST  = 8'h80;
   localparam logic [7:0]  PROG_CFG_RST  = 8'h80;
   localparam logic [15:0] FAULT_ADR_RST = 16'h0000;
   localparam logic        RST_EN_RST    = 1'b0;

   // data sram geometry
   localparam int SRAM_WORDS = 2048;
   localparam int SRAM_AW    = 11;
   localparam int SRAM_W     = 13;

   function automatic logic [31:0] byte_addr(input logic [15:0] idx);
      byte_addr = {14'h0000, idx, 2'b00};
   endfunction

   // 8:5 code, hamming positions 3,5,6,7,9,10,11,12 plus overall parity
   function automatic logic [4:0] data_check(input logic [7:0] d);
      logic [3:0] c;
      c[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
      c[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
      c[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
      c[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
      data_check = {(^d) ^ (^c), c};
   endfunction

   // 4:4 nibble code, hamming positions 3,5,6,7 plus overall parity
   function automatic logic [3:0] nib_check(input logic [3:0] n);
      logic [2:0] c;
      c[0] = n[0] ^ n[1] ^ n[3];
      c[1] = n[0] ^ n[2] ^ n[3];
      c[2] = n[1] ^ n[2] ^ n[3];
      nib_check = {(^n) ^ (^c), c};
   endfunction
endpackage
`default_nettype wire

// *** logic/ecm_ecc_if.sv ***
`default_nettype none
interface ecm_ecc_if;
   logic [15:0] raw;
   logic [7:0]  fixed;
   logic        corr;
   logic        uncorr;
   modport chk  (input raw, output fixed, output corr, output uncorr);
   modport user (output raw, input fixed, input corr, input uncorr);
endinterface
`default_nettype wire

// *** logic/ecm_data_dec.sv ***
`default_nettype none
module ecm_data_dec (
   ecm_ecc_if.chk e   // raw[12:0] = {check[4:0], data[7:0]}
);
   logic [3:0] syn;
   logic       par;
   logic [4:0] gen;

   always_comb begin
      gen = ecm_pkg::data_check(e.raw[7:0]);
      syn = e.raw[11:8] ^ gen[3:0];
      par = ^e.raw[12:0];
      e.fixed = e.raw[7:0];
      e.corr = 1'b0;
      e.uncorr = 1'b0;
      if (par) begin
         e.corr = 1'b1;
         case (syn)
            4'h0, 4'h1, 4'h2, 4'h4, 4'h8: e.fixed = e.raw[7:0];
            4'h3: e.fixed[0] = ~e.raw[0];
            4'h5: e.fixed[1] = ~e.raw[1];
            4'h6: e.fixed[2] = ~e.raw[2];
            4'h7: e.fixed[3] = ~e.raw[3];
            4'h9: e.fixed[4] = ~e.raw[4];
            4'ha: e.fixed[5] = ~e.raw[5];
            4'hb: e.fixed[6] = ~e.raw[6];
            4'hc: e.fixed[7] = ~e.raw[7];
            default: begin
               // odd parity with an impossible position: three or more flips
               e.corr = 1'b0;
               e.uncorr = 1'b1;
            end
         endcase
      end else if (syn != 4'h0) begin
         e.uncorr = 1'b1;
      end
   end
endmodule
`default_nettype wire

// *** logic/ecm_prog_dec.sv ***
`default_nettype none
module ecm_prog_dec (
   ecm_ecc_if.chk e   // raw = flash word, check bytes in [15:8]
);
   // returns {uncorr, corr, nibble}
   function automatic logic [5:0] dec_nib(input logic [3:0] d, input logic [3:0] c);
      logic [2:0] s;
      logic       p;
      logic [3:0] f;
      logic       k;
      logic       u;
      logic [3:0] g;
      g = ecm_pkg::nib_check(d);
      s = c[2:0] ^ g[2:0];
      p = (^d) ^ (^c);
      f = d;
      k = 1'b0;
      u = 1'b0;
      if (p) begin
         k = 1'b1;
         case (s)
            3'h3: f[0] = ~d[0];
            3'h5: f[1] = ~d[1];
            3'h6: f[2] = ~d[2];
            3'h7: f[3] = ~d[3];
            default: f = d;
         endcase
      end else if (s != 3'h0) begin
         u = 1'b1;
      end
      dec_nib = {u, k, f};
   endfunction

   logic [5:0] hi;
   logic [5:0] lo;

   always_comb begin
      hi = dec_nib(e.raw[7:4], e.raw[15:12]);
      lo = dec_nib(e.raw[3:0], e.raw[11:8]);
      e.fixed = {hi[3:0], lo[3:0]};
      e.uncorr = hi[5] | lo[5];
      e.corr = (hi[4] | lo[4]) & ~e.uncorr;
   end
endmodule
`default_nettype wire

// *** logic/ecm_top.sv ***
// The APB register port is this design's own decision.
`default_nettype none
module ecm_top (
   input  wire logic        clk,               // 125 MHz system clock
   input  wire logic        reset,             // async, active high
   input  wire logic        psel,              // apb select
   input  wire logic        penable,           // apb access phase
   input  wire logic        pwrite,            // apb direction
   input  wire logic [31:0] paddr,             // apb byte address
   input  wire logic [31:0] pwdata,            // apb write data
   output logic      [31:0] prdata,            // apb read data
   output logic             pready,            // apb ready
   output logic             pslverr,           // apb error, unmapped
   input  wire logic        mem_wr,            // sram byte write
   input  wire logic        mem_rd,            // sram byte read
   input  wire logic [15:0] mem_addr,          // sram byte address
   input  wire logic [7:0]  mem_wdata,         // sram write byte
   output logic      [7:0]  mem_rdata,         // sram read byte
   output logic             mem_rvalid,        // read byte valid pulse
   input  wire logic        fetch_valid,       // flash word present
   input  wire logic [15:0] fetch_addr,        // fetch address
   input  wire logic [15:0] fetch_word,        // raw flash word
   output logic      [7:0]  code_byte,         // corrected code byte
   output logic             code_valid,        // code byte valid pulse
   output logic             data_uncorr_irq,   // data uncorrectable irq
   output logic             data_corr_irq,     // data correctable irq
   output logic             prog_uncorr_irq,   // program uncorrectable irq
   output logic             prog_corr_irq,     // program correctable irq
   output logic             fetch_fault_reset  // reset request pulse on uncorrectable fetch
);
   // sram array and read pipeline
   logic [ecm_pkg::SRAM_W-1:0] sram [ecm_pkg::SRAM_WORDS];
   logic [ecm_pkg::SRAM_W-1:0] raw_r;
   logic                       rd_pend_r;
   logic [15:0]                rd_addr_r;
   logic [7:0]                 mem_rdata_r;
   logic                       mem_rvalid_r;

   // registers
   logic        data_correction_enable_r;
   logic        data_uncorr_irq_enable_r;
   logic        data_corr_irq_enable_r;
   logic        data_uncorr_flag_r;
   logic        data_corr_flag_r;
   logic [15:0] data_fault_address_r;
   logic        prog_cfg_top_r;
   logic        prog_uncorr_irq_enable_r;
   logic        prog_corr_irq_enable_r;
   logic        prog_uncorr_flag_r;
   logic        prog_corr_flag_r;
   logic [15:0] prog_fault_address_r;
   logic        fetch_fault_reset_enable_r;
   logic [7:0]  code_byte_r;
   logic        code_valid_r;
   logic        fetch_fault_reset_r;
   logic [31:0] prdata_r;

   // bus decode
   logic        setup;
   logic        wr_acc;
   logic        hit_data_cfg;
   logic        hit_prog_cfg;
   logic        hit_rst_ctrl;
   logic        mapped;
   logic [7:0]  rd_mux;

   // events
   logic        dcorr_ev;
   logic        duncorr_ev;
   logic        pcorr_ev;
   logic        puncorr_ev;

   ecm_ecc_if dbus ();
   ecm_ecc_if pbus ();

   ecm_data_dec u_data_dec (
      .e (dbus.chk)
   );

   ecm_prog_dec u_prog_dec (
      .e (pbus.chk)
   );

   function automatic logic hit(input logic [31:0] a, input logic [15:0] idx);
      hit = (a == ecm_pkg::byte_addr(idx));
   endfunction

   // software clears with a 0, a hardware set in the same cycle wins
   function automatic logic flag_nxt(input logic flag, input logic ev,
                                     input logic wr, input logic wbit);
      flag_nxt = ev | (flag & ~(wr & ~wbit));
   endfunction

   assign dbus.raw = {3'b000, raw_r};
   // low byte is code, high byte is its check bits
   assign pbus.raw = fetch_word;

   // ------------------------------------------------------------ apb
   assign setup        = psel & ~penable;
   assign wr_acc       = psel & penable & pwrite;
   assign hit_data_cfg = hit(paddr, ecm_pkg::DATA_CFG_IDX);
   assign hit_prog_cfg = hit(paddr, ecm_pkg::PROG_CFG_IDX);
   assign hit_rst_ctrl = hit(paddr, ecm_pkg::RST_CTRL_IDX);
   assign mapped       = hit_data_cfg | hit_prog_cfg | hit_rst_ctrl
                       | hit(paddr, ecm_pkg::DATA_FA_LO_IDX)
                       | hit(paddr, ecm_pkg::DATA_FA_HI_IDX)
                       | hit(paddr, ecm_pkg::PROG_FA_LO_IDX)
                       | hit(paddr, ecm_pkg::PROG_FA_HI_IDX);
   // zero wait states; registers are always ready
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata  = prdata_r;

   always_comb begin
      rd_mux = 8'h00;
      if (hit_data_cfg) begin
         rd_mux[ecm_pkg::CFG_EN_BIT]      = data_correction_enable_r;
         rd_mux[ecm_pkg::UNCORR_IEN_BIT]  = data_uncorr_irq_enable_r;
         rd_mux[ecm_pkg::CORR_IEN_BIT]    = data_corr_irq_enable_r;
         rd_mux[ecm_pkg::UNCORR_FLAG_BIT] = data_uncorr_flag_r;
         rd_mux[ecm_pkg::CORR_FLAG_BIT]   = data_corr_flag_r;
      end else if (hit_prog_cfg) begin
         rd_mux[ecm_pkg::CFG_EN_BIT]      = prog_cfg_top_r;
         rd_mux[ecm_pkg::UNCORR_IEN_BIT]  = prog_uncorr_irq_enable_r;
         rd_mux[ecm_pkg::CORR_IEN_BIT]    = prog_corr_irq_enable_r;
         rd_mux[ecm_pkg::UNCORR_FLAG_BIT] = prog_uncorr_flag_r;
         rd_mux[ecm_pkg::CORR_FLAG_BIT]   = prog_corr_flag_r;
      end else if (hit(paddr, ecm_pkg::DATA_FA_LO_IDX)) begin
         rd_mux = data_fault_address_r[7:0];
      end else if (hit(paddr, ecm_pkg::DATA_FA_HI_IDX)) begin
         rd_mux = data_fault_address_r[15:8];
      end else if (hit(paddr, ecm_pkg::PROG_FA_LO_IDX)) begin
         rd_mux = prog_fault_address_r[7:0];
      end else if (hit(paddr, ecm_pkg::PROG_FA_HI_IDX)) begin
         rd_mux = prog_fault_address_r[15:8];
      end
      // reset-enable bit is write-only and reads as zero
   end

   // sampled in setup so read data leaves a flop in the access phase
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prdata_r <= 32'h0000_0000;
      end else if (setup) begin
         prdata_r <= {24'h00_0000, rd_mux};
      end
   end

   // ------------------------------------------------------------ sram side
   // store data with its five check bits
   // encode on every write, no software step
   always_ff @(posedge clk) begin
      if (mem_wr) begin
         sram[mem_addr[ecm_pkg::SRAM_AW-1:0]] <= {ecm_pkg::data_check(mem_wdata), mem_wdata};
      end
   end

   // a read in the same cycle as a write is dropped; write wins
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rd_pend_r <= 1'b0;
         rd_addr_r <= 16'h0000;
         raw_r     <= 13'h0000;
      end else begin
         rd_pend_r <= mem_rd & ~mem_wr;
         if (mem_rd & ~mem_wr) begin
            rd_addr_r <= mem_addr;
            raw_r     <= sram[mem_addr[ecm_pkg::SRAM_AW-1:0]];
         end
      end
   end

   // every read is checked while correction is on
   assign dcorr_ev   = rd_pend_r & data_correction_enable_r & dbus.corr;
   assign duncorr_ev = rd_pend_r & data_correction_enable_r & dbus.uncorr;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mem_rdata_r  <= 8'h00;
         mem_rvalid_r <= 1'b0;
      end else begin
         mem_rvalid_r <= rd_pend_r;
         if (rd_pend_r) begin
            mem_rdata_r <= data_correction_enable_r ? dbus.fixed : raw_r[7:0];
         end
      end
   end

   assign mem_rdata  = mem_rdata_r;
   assign mem_rvalid = mem_rvalid_r;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         data_correction_enable_r <= ecm_pkg::DATA_CFG_RST[ecm_pkg::CFG_EN_BIT];
         data_uncorr_irq_enable_r <= ecm_pkg::DATA_CFG_RST[ecm_pkg::UNCORR_IEN_BIT];
         data_corr_irq_enable_r   <= ecm_pkg::DATA_CFG_RST[ecm_pkg::CORR_IEN_BIT];
      end else if (wr_acc & hit_data_cfg) begin
         data_correction_enable_r <= pwdata[ecm_pkg::CFG_EN_BIT];
         data_uncorr_irq_enable_r <= pwdata[ecm_pkg::UNCORR_IEN_BIT];
         data_corr_irq_enable_r   <= pwdata[ecm_pkg::CORR_IEN_BIT];
      end
   end

   // uncorrectable flag, irq enable does not gate it, correction enable does
   // correctable flag, irq enable does not gate it, correction enable does
   // clear by writing zero, set beats clear
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         data_uncorr_flag_r <= ecm_pkg::DATA_CFG_RST[ecm_pkg::UNCORR_FLAG_BIT];
         data_corr_flag_r   <= ecm_pkg::DATA_CFG_RST[ecm_pkg::CORR_FLAG_BIT];
      end else begin
         data_uncorr_flag_r <= flag_nxt(data_uncorr_flag_r, duncorr_ev,
                                        wr_acc & hit_data_cfg,
                                        pwdata[ecm_pkg::UNCORR_FLAG_BIT]);
         data_corr_flag_r   <= flag_nxt(data_corr_flag_r, dcorr_ev,
                                        wr_acc & hit_data_cfg,
                                        pwdata[ecm_pkg::CORR_FLAG_BIT]);
      end
   end

   // frozen while an earlier fault is still flagged
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         data_fault_address_r <= ecm_pkg::FAULT_ADR_RST;
      end else if ((dcorr_ev | duncorr_ev) & ~(data_uncorr_flag_r | data_corr_flag_r)) begin
         data_fault_address_r <= rd_addr_r;
      end
   end

   // ------------------------------------------------------------ fetch side
   // both nibbles checked against their own field
   // check runs in the fetch cycle itself
   assign pcorr_ev   = fetch_valid & pbus.corr;
   assign puncorr_ev = fetch_valid & pbus.uncorr;

   // corrected code byte to the core
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         code_byte_r  <= 8'h00;
         code_valid_r <= 1'b0;
      end else begin
         code_valid_r <= fetch_valid;
         if (fetch_valid) begin
            code_byte_r <= pbus.fixed;
         end
      end
   end

   assign code_byte  = code_byte_r;
   assign code_valid = code_valid_r;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prog_cfg_top_r           <= ecm_pkg::PROG_CFG_RST[ecm_pkg::CFG_EN_BIT];
         prog_uncorr_irq_enable_r <= ecm_pkg::PROG_CFG_RST[ecm_pkg::UNCORR_IEN_BIT];
         prog_corr_irq_enable_r   <= ecm_pkg::PROG_CFG_RST[ecm_pkg::CORR_IEN_BIT];
      end else if (wr_acc & hit_prog_cfg) begin
         prog_cfg_top_r           <= pwdata[ecm_pkg::CFG_EN_BIT];
         prog_uncorr_irq_enable_r <= pwdata[ecm_pkg::UNCORR_IEN_BIT];
         prog_corr_irq_enable_r   <= pwdata[ecm_pkg::CORR_IEN_BIT];
      end
   end

   // uncorrectable fetch flag, independent of enable
   // correctable fetch flag, independent of enable
   // clear by writing zero, set beats clear
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prog_uncorr_flag_r <= ecm_pkg::PROG_CFG_RST[ecm_pkg::UNCORR_FLAG_BIT];
         prog_corr_flag_r   <= ecm_pkg::PROG_CFG_RST[ecm_pkg::CORR_FLAG_BIT];
      end else begin
         prog_uncorr_flag_r <= flag_nxt(prog_uncorr_flag_r, puncorr_ev,
                                        wr_acc & hit_prog_cfg,
                                        pwdata[ecm_pkg::UNCORR_FLAG_BIT]);
         prog_corr_flag_r   <= flag_nxt(prog_corr_flag_r, pcorr_ev,
                                        wr_acc & hit_prog_cfg,
                                        pwdata[ecm_pkg::CORR_FLAG_BIT]);
      end
   end

   // latch fetch address on any fetch fault
   // always the latest fault, software cannot write it
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prog_fault_address_r <= ecm_pkg::FAULT_ADR_RST;
      end else if (pcorr_ev | puncorr_ev) begin
         prog_fault_address_r <= fetch_addr;
      end
   end

   // reset-enable control, cleared by any reset
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fetch_fault_reset_enable_r <= ecm_pkg::RST_EN_RST;
      end else if (wr_acc & hit_rst_ctrl) begin
         fetch_fault_reset_enable_r <= pwdata[ecm_pkg::RST_EN_BIT];
      end
   end

   // reset request replaces the interrupt when enabled
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fetch_fault_reset_r <= 1'b0;
      end else begin
         fetch_fault_reset_r <= puncorr_ev & fetch_fault_reset_enable_r;
      end
   end

   assign fetch_fault_reset = fetch_fault_reset_r;

   assign data_uncorr_irq = data_uncorr_flag_r & data_uncorr_irq_enable_r;
   assign data_corr_irq   = data_corr_flag_r & data_corr_irq_enable_r;
   assign prog_corr_irq   = prog_corr_flag_r & prog_corr_irq_enable_r;
   // in reset mode the uncorrectable fetch irq stays quiet
   assign prog_uncorr_irq = prog_uncorr_flag_r & prog_uncorr_irq_enable_r
                          & ~fetch_fault_reset_enable_r;
endmodule
`default_nettype wire

// *** testbench/ecm_checker.sv ***
`default_nettype none
module ecm_checker (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic        mem_wr,
   input wire logic        mem_rd,
   input wire logic        mem_rvalid,
   input wire logic        fetch_valid,
   input wire logic [15:0] fetch_word,
   input wire logic [7:0]  code_byte,
   input wire logic        code_valid,
   input wire logic        fetch_fault_reset,
   input wire logic        data_corr_irq,
   input wire logic        prog_corr_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   wire apb_wr = psel && penable && pwrite;

   function automatic logic [3:0] nc(input logic [3:0] n);
      logic [2:0] c;
      c = {n[1] ^ n[2] ^ n[3], n[0] ^ n[2] ^ n[3], n[0] ^ n[1] ^ n[3]};
      nc = {^{n, c}, c};
   endfunction

   a_rd_latency: assert property (mem_rd && !mem_wr |-> ##2 mem_rvalid)
      else $error("read answer late");
   a_rd_cause: assert property (mem_rvalid |-> $past(mem_rd && !mem_wr, 2))
      else $error("read answer without request");
   a_fetch_latency: assert property (fetch_valid |=> code_valid)
      else $error("code byte late");
   a_fetch_cause: assert property (code_valid |-> $past(fetch_valid))
      else $error("code byte without fetch");
   a_clean_code: assert property (fetch_valid && fetch_word[15:8] ==
      {nc(fetch_word[7:4]), nc(fetch_word[3:0])} |=>
      code_byte == $past(fetch_word[7:0]) && !fetch_fault_reset)
      else $error("clean word altered");
   a_reset_cause: assert property (fetch_fault_reset |-> $past(fetch_valid))
      else $error("reset request without fetch");
   a_irq_fall: assert property ($fell(data_corr_irq) || $fell(prog_corr_irq)
      |-> $past(apb_wr)) else $error("irq dropped without write");
   a_prog_rise: assert property ($rose(prog_corr_irq) |-> code_valid || $past(apb_wr))
      else $error("irq raised without cause");

   c_read: cover property (mem_rvalid);
   c_corr: cover property (prog_corr_irq);
   c_reset: cover property (fetch_fault_reset);
endmodule
bind ecm_top ecm_checker i_ecm_checker (.*);
`default_nettype wire

// *** testbench/ecm_flash_model.sv ***
`default_nettype none
module ecm_flash_model (
   input  wire logic [15:0] addr, // fetch address
   input  wire logic [15:0] flip, // injected upsets
   output logic      [15:0] word  // word as the array returns it
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] code;

   function automatic logic [3:0] nc(input logic [3:0] n);
      logic [2:0] c;
      c = {n[1] ^ n[2] ^ n[3], n[0] ^ n[2] ^ n[3], n[0] ^ n[1] ^ n[3]};
      nc = {^{n, c}, c};
   endfunction

   // code derived from address so the bench needs no image
   assign code = addr[7:0] ^ addr[15:8];
   assign word = {nc(code[7:4]), nc(code[3:0]), code} ^ flip;
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, reset, psel, penable, pwrite, pready, pslverr, err, re;
   logic        mem_wr, mem_rd, mem_rvalid, fetch_valid, code_valid, fetch_fault_reset;
   logic        data_uncorr_irq, data_corr_irq, prog_uncorr_irq, prog_corr_irq;
   logic [31:0] paddr, pwdata, prdata;
   logic [15:0] mem_addr, fetch_addr, fetch_word, flip, a, f;
   logic [7:0]  mem_wdata, mem_rdata, code_byte, r8;
   logic [1:0]  c, en;
   int          num_errors = 0;
   int          tests_run = 0;
   int          p;

   ecm_top i_ecm_top (.*);
   ecm_flash_model i_ecm_flash_model (.addr(fetch_addr), .flip(flip), .word(fetch_word));

   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask

   // one idle edge between transfers, so no strobe is set twice per step
   task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] v);
      @(posedge clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= {14'h0000, idx, 2'b00};
      pwdata <= {24'h000000, v};
      @(posedge clk);
      penable <= 1;
      // no limit here; only the watchdog ends a hung transfer
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r8 = prdata[7:0];
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   task automatic rd(input logic [15:0] idx, input logic [7:0] e);
      apb(1'b0, idx, 8'h00);
      chk(r8, e);
   endtask

   // write then read the same byte on the very next cycle
   task automatic mwr(input logic [15:0] ad, input logic [7:0] v);
      @(posedge clk);
      mem_wr <= 1;
      mem_addr <= ad;
      mem_wdata <= v;
      @(posedge clk);
      mem_wr <= 0;
      mem_rd <= 1;
      @(posedge clk);
      mem_rd <= 0;
      while (mem_rvalid !== 1'b1) begin
         @(posedge clk);
      end
      chk(mem_rdata, v);
   endtask

   task automatic fetch(input logic [15:0] ad, input logic [15:0] m);
      @(posedge clk);
      fetch_valid <= 1;
      fetch_addr <= ad;
      flip <= m;
      @(posedge clk);
      fetch_valid <= 0;
      #1;
   endtask

   // upsets counted per nibble group: data nibble plus its four checks
   function automatic logic [1:0] cls(input logic [15:0] m);
      int h, l;
      h = $countones({m[15:12], m[7:4]});
      l = $countones({m[11:8], m[3:0]});
      cls = {h > 1 || l > 1, (h == 1 || l == 1) && h < 2 && l < 2};
   endfunction

   task automatic tally_and_finish;
      $display("errors %0d of %0d checks", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      tally_and_finish;
   end

   initial begin
      {psel, penable, pwrite, mem_wr, mem_rd, fetch_valid} = '0;
      {paddr, pwdata, mem_addr, mem_wdata, fetch_addr, flip} = '0;
      reset = 1;
      p = $urandom(32'h2f8059eb);
      repeat (10) @(posedge clk);
      reset <= 0;
      rd(ecm_pkg::DATA_CFG_IDX, 8'h80);
      rd(ecm_pkg::PROG_CFG_IDX, 8'h80);
      rd(ecm_pkg::RST_CTRL_IDX, 8'h00);
      apb(1'b1, ecm_pkg::PROG_FA_LO_IDX, 8'h5a);
      rd(ecm_pkg::PROG_FA_LO_IDX, 8'h00);
      apb(1'b1, 16'h0100, 8'h5a);
      chk({err, r8}, 9'h100);
      for (p = 0; p < 8; p++) begin
         if (p == 4) apb(1'b1, ecm_pkg::DATA_CFG_IDX, 8'h30);
         mwr(16'($urandom), 8'($urandom));
      end
      rd(ecm_pkg::DATA_CFG_IDX, 8'h30);
      chk({data_uncorr_irq, data_corr_irq}, 2'b00);
      rd(ecm_pkg::DATA_FA_HI_IDX, 8'h00);
      for (p = 0; p < 48; p++) begin
         en = 2'($urandom);
         re = 1'($urandom);
         a = 16'($urandom);
         f = (p % 3 == 0) ? 16'h0000 : 16'h0001 << $urandom_range(15);
         if (p % 3 == 2) f = f | (16'h0001 << $urandom_range(15));
         apb(1'b1, ecm_pkg::PROG_CFG_IDX, {2'b10, en, 4'h0});
         apb(1'b1, ecm_pkg::RST_CTRL_IDX, {1'b0, re, 6'h00});
         fetch(a, f);
         c = cls(f);
         chk(code_valid, 1'b1);
         if (!c[1]) chk(code_byte, a[7:0] ^ a[15:8]);
         chk(fetch_fault_reset, c[1] & re);
         chk({prog_uncorr_irq, prog_corr_irq}, c & en & {~re, 1'b1});
         rd(ecm_pkg::PROG_CFG_IDX, {2'b10, en, 2'b00, c});
         if (c != 2'b00) begin
            rd(ecm_pkg::PROG_FA_LO_IDX, a[7:0]);
            rd(ecm_pkg::PROG_FA_HI_IDX, a[15:8]);
         end
         apb(1'b1, ecm_pkg::PROG_CFG_IDX, {2'b10, en, 4'h3});
         rd(ecm_pkg::PROG_CFG_IDX, {2'b10, en, 2'b00, c});
         apb(1'b1, ecm_pkg::PROG_CFG_IDX, 8'h80);
         rd(ecm_pkg::PROG_CFG_IDX, 8'h80);
      end
      reset <= 1;
      repeat (2) @(posedge clk);
      reset <= 0;
      rd(ecm_pkg::PROG_FA_LO_IDX, 8'h00);
      tally_and_finish;
   end
endmodule
`default_nettype wire
